/* File: core/mds_pkg.sv */
package mds_pkg;
   localparam int DATA_W = 16;
   localparam int MUL_W = 17;
   localparam int PROD_W = 34;
   localparam int SHIFT_W = 40;
   localparam int SHAMT_W = 5;
   localparam logic [4:0] MAX_SHIFT = 5'h10;
   localparam int DIV_CYCLES = 19;
   localparam int DIV_STEPS = 18;
   localparam logic [4:0] DIV_LAST = 5'h12;
   localparam logic [4:0] DIV_FIRST_STEP = 5'h01;
   localparam logic [4:0] DIV_SHIFT_STEPS = 5'h11;
   localparam logic [4:0] DIV_WORD_BITS = 5'h10;
   localparam logic [1:0] SIGN_UU = 2'h0;
   localparam logic [1:0] SIGN_SS = 2'h1;
   localparam logic [1:0] SIGN_SU = 2'h2;
   localparam logic [1:0] SIGN_US = 2'h3;
   typedef enum logic [1:0] {div_idle_type_v, div_run_type_v,
      div_hold_type_v} div_state_type;
endpackage

/* File: core/barrel_shift40.sv */
`timescale 1ns/1ps
module barrel_shift40
(
   input wire logic [39:0] din,
   input wire logic [4:0] amount,
   input wire logic left,
   input wire logic arith,
   output logic [39:0] dout
);
   logic [4:0] amt;
   always_comb
   begin
      // Amounts past sixteen are clipped to keep the shifter single cycle
      amt = (amount > mds_pkg::MAX_SHIFT) ? mds_pkg::MAX_SHIFT : amount;
      if (left)
         dout = din << amt;
      else if (arith)
         dout = 40'($signed(din) >>> amt);
      else
         dout = din >> amt;
   end
endmodule

/* File: core/mul_div_shift_datapath.sv */
`timescale 1ns/1ps
module mul_div_shift_datapath
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic mul_req,
   input wire logic mul_dsp,
   input wire logic [1:0] mul_sign,
   input wire logic mul_frac,
   input wire logic [15:0] mul_a,
   input wire logic [15:0] mul_b,
   input wire logic shift_req,
   input wire logic shift_dsp,
   input wire logic shift_left,
   input wire logic shift_arith,
   input wire logic [4:0] shift_amount,
   input wire logic [39:0] shift_alu_in,
   input wire logic [39:0] shift_dsp_in,
   input wire logic div_start,
   input wire logic div_step,
   input wire logic div_wide,
   input wire logic div_signed,
   input wire logic div_frac,
   input wire logic [31:0] div_dividend,
   input wire logic [15:0] div_divisor,
   input wire logic int_hold,
   output logic [33:0] mul_result,
   output logic mul_valid,
   output logic mul_to_dsp,
   output logic [39:0] shift_result,
   output logic shift_valid,
   output logic shift_to_dsp,
   output logic div_busy,
   output logic div_done,
   output logic [15:0] quotient,
   output logic [15:0] remainder
);
   logic signed [16:0] op_a;
   logic signed [16:0] op_b;
   logic signed [33:0] next_product;
   logic [39:0] shifter_in;
   logic [39:0] next_shift;
   mds_pkg::div_state_type div_state;
   logic [4:0] div_count;
   logic [31:0] rem_acc;
   logic [15:0] dvsr;
   logic [15:0] quo_acc;
   logic neg_q;
   logic neg_r;
   logic [16:0] trial;

   // Sign extend or zero extend each operand to 17 bits
   always_comb
   begin
      op_a = {(mul_sign == mds_pkg::SIGN_SS || mul_sign == mds_pkg::SIGN_SU)
              & mul_a[15], mul_a};
      op_b = {(mul_sign == mds_pkg::SIGN_SS || mul_sign == mds_pkg::SIGN_US)
              & mul_b[15], mul_b};
      // 34 product bits hold 0x8000*0x8000 doubled so fractional -1 x -1 does not wrap
      next_product = op_a * op_b;
      if (mul_frac)
         next_product = next_product <<< 1;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mul_result <= 34'h0;
         mul_valid <= 1'b0;
         mul_to_dsp <= 1'b0;
      end
      else
      begin
         mul_valid <= mul_req;
         mul_to_dsp <= mul_dsp;
         if (mul_req)
            mul_result <= next_product;
      end
   end

   // DSP path wins the single shifter when it requests
   assign shifter_in = shift_dsp ? shift_dsp_in : shift_alu_in;

   barrel_shift40 u_shift
   (
      .din(shifter_in),
      .amount(shift_amount),
      .left(shift_left),
      .arith(shift_arith),
      .dout(next_shift)
   );

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         shift_result <= 40'h0;
         shift_valid <= 1'b0;
         shift_to_dsp <= 1'b0;
      end
      else
      begin
         shift_valid <= shift_req;
         shift_to_dsp <= shift_dsp;
         if (shift_req)
            shift_result <= next_shift;
      end
   end

   // Restoring divide on magnitudes; one quotient bit per step for the first 16 steps
   assign trial = {rem_acc[31:15]} - {1'b0, dvsr};

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_state <= mds_pkg::div_idle_type_v;
         div_count <= 5'h0;
         rem_acc <= 32'h0;
         dvsr <= 16'h0;
         quo_acc <= 16'h0;
         neg_q <= 1'b0;
         neg_r <= 1'b0;
      end
      else
      begin
         case (div_state)
            mds_pkg::div_idle_type_v:
            begin
               if (div_start)
               begin
                  neg_q <= div_signed & ((div_wide ? div_dividend[31]
                     : div_dividend[15]) ^ div_divisor[15]);
                  neg_r <= div_signed & (div_wide ? div_dividend[31]
                     : div_dividend[15]);
                  dvsr <= (div_signed & div_divisor[15]) ?
                     16'(-div_divisor) : div_divisor;
                  if (div_wide)
                     rem_acc <= (div_signed & div_dividend[31]) ?
                        32'(-div_dividend) : div_dividend;
                  else if (div_frac)
                     rem_acc <= {((div_signed & div_dividend[15]) ?
                        16'(-div_dividend[15:0]) : div_dividend[15:0]),
                        16'h0};
                  else
                     rem_acc <= {16'h0, (div_signed & div_dividend[15]) ?
                        16'(-div_dividend[15:0]) : div_dividend[15:0]};
                  quo_acc <= 16'h0;
                  div_count <= mds_pkg::DIV_FIRST_STEP;
                  div_state <= mds_pkg::div_run_type_v;
               end
            end
            mds_pkg::div_run_type_v:
            begin
               if (int_hold)
                  div_state <= mds_pkg::div_hold_type_v;
               else if (div_step)
               begin
                  if (div_count <= mds_pkg::DIV_WORD_BITS)
                  begin
                     if (!trial[16])
                     begin
                        rem_acc <= {trial[15:0], rem_acc[14:0], 1'b0};
                        quo_acc <= {quo_acc[14:0], 1'b1};
                     end
                     else
                     begin
                        rem_acc <= {rem_acc[30:0], 1'b0};
                        quo_acc <= {quo_acc[14:0], 1'b0};
                     end
                  end
                  else if (div_count == mds_pkg::DIV_SHIFT_STEPS)
                  begin
                     // Extra step applies signs before the result cycle
                     if (neg_q)
                        quo_acc <= 16'(-quo_acc);
                     if (neg_r)
                        rem_acc[31:16] <= 16'(-rem_acc[31:16]);
                  end
                  if (div_count == mds_pkg::DIV_LAST)
                     div_state <= mds_pkg::div_idle_type_v;
                  div_count <= div_count + 5'h1;
               end
            end
            mds_pkg::div_hold_type_v:
            begin
               // Partial quotient and remainder are frozen here
               if (!int_hold)
                  div_state <= mds_pkg::div_run_type_v;
            end
            default:
               div_state <= mds_pkg::div_idle_type_v;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_busy <= 1'b0;
         div_done <= 1'b0;
         quotient <= 16'h0;
         remainder <= 16'h0;
      end
      else
      begin
         div_done <= 1'b0;
         if (div_state == mds_pkg::div_idle_type_v && div_start)
            div_busy <= 1'b1;
         if (div_state == mds_pkg::div_run_type_v && !int_hold &&
             div_step && div_count == mds_pkg::DIV_LAST)
         begin
            div_busy <= 1'b0;
            div_done <= 1'b1;
            quotient <= quo_acc;
            remainder <= rem_acc[31:16];
         end
      end
   end

   // Start cycle plus 18 steps gives the 19 cycle divide
   AST_MUL_ONE_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
      mul_req |=> mul_valid) else $error("mul late");
   AST_MUL_UNS: assert property (@(posedge clk) disable iff (!nrst)
      mul_req && mul_sign == mds_pkg::SIGN_UU && !mul_frac |=>
      mul_result == {18'h0, $past(mul_a)} * {18'h0, $past(mul_b)})
      else $error("unsigned product wrong");
   AST_MUL_MINUS1: assert property (@(posedge clk) disable iff (!nrst)
      mul_req && mul_frac && mul_sign == mds_pkg::SIGN_SS &&
      mul_a == 16'h8000 && mul_b == 16'h8000 |=>
      mul_result == 34'h080000000) else $error("-1x-1 wrong");
   AST_SHIFT_ONE: assert property (@(posedge clk) disable iff (!nrst)
      shift_req |=> shift_valid) else $error("shift late");
   AST_SHIFT_SHARE: assert property (@(posedge clk) disable iff (!nrst)
      shift_req && shift_dsp && shift_left && shift_amount == 5'h1 |=>
      shift_result == {$past(shift_dsp_in[38:0]), 1'b0})
      else $error("dsp shift wrong");
   AST_DIV_19: assert property (@(posedge clk) disable iff (!nrst)
      div_state == mds_pkg::div_idle_type_v && div_start ##1
      (div_step && !int_hold) [*8] ##1 (div_step && !int_hold) [*8]
      ##1 (div_step && !int_hold) ##1 (div_step && !int_hold) |=>
      div_done) else $error("divide not 19 cycles");
   AST_DIV_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      div_state == mds_pkg::div_hold_type_v |=>
      $stable(quo_acc) && $stable(rem_acc) && $stable(div_count))
      else $error("held divide changed");
   AST_DIV_RESULT: assert property (@(posedge clk) disable iff (!nrst)
      div_done |-> !div_busy && $changed(div_done))
      else $error("done while busy");
   AST_DIV_16: assert property (@(posedge clk) disable iff (!nrst)
      div_done && !neg_q && !neg_r |-> quotient == quo_acc)
      else $error("quotient lost");
   COV_MUL: cover property (@(posedge clk) mul_req && mul_frac);
   COV_SHIFT: cover property (@(posedge clk) shift_req && shift_dsp);
   COV_DIV: cover property (@(posedge clk) div_done);
   COV_HOLD: cover property (@(posedge clk)
      div_state == mds_pkg::div_hold_type_v);
endmodule

/* File: test/div_ctrl_model.sv */
`timescale 1ns/1ps
module div_ctrl_model
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic go,
   input wire logic hold_en,
   input wire logic div_done,
   output logic div_start,
   output logic div_step,
   output logic int_hold
);
   logic active;
   // Random stalls so a hold can land on any divide step after the first
   always @(negedge clk)
   begin
      if (!nrst)
      begin
         active <= 1'b0;
         div_start <= 1'b0;
         div_step <= 1'b0;
         int_hold <= 1'b0;
      end
      else
      begin
         int_hold <= div_step && !div_done && hold_en && 1'($urandom);
         if (go && !active)
         begin
            active <= 1'b1;
            div_start <= 1'b1;
         end
         else if (div_start)
         begin
            div_start <= 1'b0;
            div_step <= 1'b1;
         end
         else if (div_done)
         begin
            div_step <= 1'b0;
            active <= 1'b0;
         end
      end
   end
endmodule

/* File: test/test_mul_div_shift_datapath.sv */
`timescale 1ns/1ps
module test_mul_div_shift_datapath;
   logic clk, nrst, mul_req, mul_dsp, mul_frac, shift_req, shift_dsp;
   logic [1:0] mul_sign;
   logic [15:0] mul_a, mul_b, div_divisor, quotient, remainder;
   logic [4:0] shift_amount;
   logic [39:0] shift_alu_in, shift_dsp_in, shift_result, es;
   logic [31:0] div_dividend;
   logic [33:0] mul_result, em;
   logic shift_left, shift_arith, div_start, div_step, div_wide;
   logic div_signed, div_frac, int_hold, mul_valid, mul_to_dsp;
   logic shift_valid, shift_to_dsp, div_busy, div_done, go, hold_en;
   logic pm, ps, pmd, psd;
   int bad_count, checked;
   mul_div_shift_datapath uut (.clk, .nrst, .mul_req, .mul_dsp, .mul_sign,
      .mul_frac, .mul_a, .mul_b, .shift_req, .shift_dsp, .shift_left,
      .shift_arith, .shift_amount, .shift_alu_in, .shift_dsp_in, .div_start,
      .div_step, .div_wide, .div_signed, .div_frac, .div_dividend,
      .div_divisor, .int_hold, .mul_result, .mul_valid, .mul_to_dsp,
      .shift_result, .shift_valid, .shift_to_dsp, .div_busy, .div_done,
      .quotient, .remainder);
   div_ctrl_model ctrl (.clk, .nrst, .go, .hold_en, .div_done, .div_start,
      .div_step, .int_hold);
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [39:0] got, exp, input string m);
      checked++;
      if (got !== exp)
      begin
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
         bad_count++;
      end
   endtask
   task automatic results;
      $display("checks %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [33:0] mexp(input logic [1:0] s,
      input logic f, input logic [15:0] a, b);
      logic [33:0] x, y;
      x = {{18{a[15] & (s == mds_pkg::SIGN_SS || s == mds_pkg::SIGN_SU)}}, a};
      y = {{18{b[15] & (s == mds_pkg::SIGN_SS || s == mds_pkg::SIGN_US)}}, b};
      return f ? (x * y) << 1 : x * y;
   endfunction
   function automatic logic [39:0] sexp(input logic l, r,
      input logic [4:0] n, input logic [39:0] d);
      int k;
      k = n > 16 ? 16 : n;
      if (l)
         return d << k;
      return r ? 40'($signed(d) >>> k) : d >> k;
   endfunction
   function automatic logic [31:0] dexp(input logic w, s, f,
      input logic [31:0] dd, input logic [15:0] dv);
      logic [31:0] x;
      longint a, b;
      x = w ? dd : f ? {dd[15:0], 16'h0} : {{16{s & dd[15]}}, dd[15:0]};
      a = s ? longint'($signed(x)) : longint'(x);
      b = s ? longint'($signed(dv)) : longint'(dv);
      return {16'(a / b), 16'(a % b)};
   endfunction
   task automatic div_run(input logic w, s, f, h);
      int n, m;
      logic [15:0] d;
      m = 2 + $urandom % 32766;
      d = f ? 16'($urandom % ((m + 1) / 2)) : 16'($urandom);
      if (f && s && $urandom % 2)
         d = -d;
      div_divisor = (s && $urandom % 2) ? -16'(m) : 16'(m);
      div_dividend = w ? (s ? {{16{d[15]}}, d} : {16'($urandom % m), d})
         : {16'($urandom), d};
      div_wide = w;
      div_signed = s;
      div_frac = f;
      hold_en = h;
      go <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      n = 1;
      while (div_done !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
         if (n == 2) chk(div_busy, 1, "busy");
      end
      if (!h) chk(n, 20, "div cycles");
      chk({quotient, remainder}, dexp(w, s, f, div_dividend,
         div_divisor), "div");
      chk(div_busy, 0, "idle");
      @(negedge clk);
      chk(div_done, 0, "done pulse");
   endtask
   initial
   begin
      void'($urandom(32'hbd7b));
      {mul_req, mul_dsp, mul_frac, shift_req, shift_dsp, mul_sign} = '0;
      {mul_a, mul_b, shift_amount, shift_alu_in, shift_dsp_in} = '0;
      {shift_left, shift_arith, div_dividend, div_divisor} = '0;
      {div_wide, div_signed, div_frac, go, hold_en, pm, ps} = '0;
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      chk({mul_valid, shift_valid, div_busy, div_done, quotient, remainder},
         0, "reset");
      for (int i = 0; i < 81; i++)
      begin
         @(negedge clk);
         chk(mul_valid, pm, "mul valid");
         if (pm) chk({mul_to_dsp, mul_result}, {pmd, em}, "mul");
         chk(shift_valid, ps, "shift valid");
         if (ps) chk(shift_result, es, "shift");
         if (ps) chk(shift_to_dsp, psd, "shift dest");
         mul_req = i < 80 && (i < 8 || $urandom % 4 != 0);
         mul_sign = i < 8 ? i[1:0] : 2'($urandom);
         mul_frac = i < 8 ? i[2] : 1'($urandom);
         mul_a = i < 8 ? 16'h8000 : 16'($urandom);
         mul_b = i < 8 ? 16'h8000 : 16'($urandom);
         mul_dsp = 1'($urandom);
         // Corner cases first: one-place DSP left shift, then clipping
         shift_req = i < 80 && (i < 6 || $urandom % 4 != 0);
         {shift_dsp, shift_left, shift_arith} = i < 4 ? 3'h6 : 3'($urandom);
         shift_amount = i < 4 ? 5'h01 : i < 6 ? 5'h1f : 5'($urandom);
         shift_alu_in = {8'($urandom), 32'($urandom)};
         shift_dsp_in = {8'($urandom), 32'($urandom)};
         em = mexp(mul_sign, mul_frac, mul_a, mul_b);
         es = sexp(shift_left, shift_arith, shift_amount,
            shift_dsp ? shift_dsp_in : shift_alu_in);
         {pm, pmd, ps, psd} = {mul_req, mul_dsp, shift_req, shift_dsp};
      end
      for (int i = 0; i < 32; i++)
         div_run(i[0], i[1], i[2], i[3]);
      results();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      $display("BAD %0t timeout", $time);
      bad_count++;
      results();
   end
endmodule
